// *** acr_pkg.sv ***
package acr_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [3:0] IDX_INPUT_DISABLE_0 = 4'h1;
  localparam logic [3:0] IDX_INPUT_DISABLE_1 = 4'h2;
  localparam logic [3:0] IDX_CONVERTER_CTRL_B = 4'h3;
  localparam logic [3:0] IDX_RESULT_LOW = 4'h4;
  localparam logic [3:0] IDX_RESULT_HIGH = 4'h5;
  localparam logic [3:0] IDX_CONVERTER_CTRL_A = 4'h6;
  localparam logic [3:0] IDX_ALIGN_CTRL = 4'h7;

  // Reset values.
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [9:0] RST_RESULT = 10'h000;

  // Control/status A bit positions.
  localparam int CA_ENABLE = 7;
  localparam int CA_START = 6;
  localparam int CA_AUTO = 5;
  localparam int CA_FLAG = 4;
  localparam int CA_IE = 3;
  localparam int CA_DIV_HI = 2;

  // Control/status B bit positions.
  localparam int CB_BIPOLAR = 7;
  localparam int CB_GAIN = 6;
  localparam int CB_REF_EXT = 4;
  localparam int CB_CH_MSB = 3;
  localparam int CB_TRIG_HI = 2;

  // Alignment control bit position.
  localparam int AL_LEFT = 0;

  // Input disable register 1 keeps only its upper nibble.
  localparam logic [7:0] DIS1_MASK = 8'hf0;
  // Writable bits of control/status B; bit 5 is reserved.
  localparam logic [7:0] CB_MASK = 8'hdf;

  // Trigger source code for free running.
  localparam logic [2:0] TRIG_FREE = 3'h0;
  // Divider codes up to and including this one divide by two.
  localparam logic [2:0] DIV_MIN_CODE = 3'h1;

  // Result saturation value in unipolar mode.
  localparam logic [9:0] RESULT_SAT = 10'h3ff;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ACR_IDLE = 2'b00,
    ACR_BUSY = 2'b01
  } acr_conv_e;

endpackage

// *** acr_adc_ctrl.sv ***
`timescale 1ns/1ps
// Functional notes
// - Completion flag sets when conversion finishes.
// - Interrupt needs flag, enable and global enable.
// - Vector execution clears the completion flag.
// - Writing one clears flag; zero leaves it.
// - Divider codes give two up to 128.
// - Right alignment puts bits 9:8 low.
// - Left alignment puts bits 9:2 high.
// - Low byte read locks results until high.
// - Unipolar result saturates when input not positive.
// - Bipolar gives two's complement, unipolar plain.
// - Gain boost swaps 20x/1x for 32x/8x.
// - Control B bit 5 always reads zero.
// - Reference extension bit selects internal reference.
// - Channel msb changes only while idle or as a conversion completes.
// - Auto trigger starts on selected flag edge.
// - Switching to set source counts as edge.
// - Selecting free running creates no trigger.
// - Trigger field decodes eight documented sources.
// - Disable bits gate analog pin inputs low.
// - Bit 3 gates the reference pin input.
// - Register 1 upper bits gate pins 10..7.
// - Clearing enable aborts running conversion.
module acr_adc_ctrl #(
  parameter int ADDR_W = 6,
  parameter int NPIN = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic global_irq_enable,
  input wire logic irq_vector_ack,
  output logic conv_done_irq,
  input wire logic [7:1] trigger_flags,
  input wire logic conv_finished,
  input wire logic [10:0] conv_raw,
  output logic conv_start,
  output logic conv_abort,
  output logic converter_enable,
  output logic conv_clk_tick,
  output logic bipolar_select,
  output logic gain_boost_select,
  output logic reference_select_ext,
  output logic channel_select_msb,
  input wire logic [NPIN-1:0] pin_in,
  output logic [NPIN-1:0] pin_in_gated,
  output logic [NPIN-1:0] pin_buffer_disable
);

  ////////////////////////////////////////////////////////////////////////////
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [7:0] wdata_ff;
  logic wstrb0_ff;
  logic wr_fire, rd_fire;
  logic [3:0] wr_idx, rd_idx;
  logic [7:0] rd_byte;
  logic rd_hit;

  logic [7:0] dis0_ff, dis1_ff, ctrl_b_ff;
  logic en_ff, auto_ff, flag_ff, ie_ff, left_ff;
  logic [2:0] div_sel_ff;
  logic [9:0] result_ff;
  logic lock_ff;
  logic ch_msb_eff_ff;
  acr_pkg::acr_conv_e state_ff;
  logic busy;
  logic [6:0] presc_ff;
  logic [6:0] div_limit;
  logic trig_level, trig_prev_ff, trig_edge;
  logic sw_start, auto_start, free_start, start_req;
  logic [9:0] conv_value;
  logic irq_ff, start_ff, abort_ff, tick_ff;
  logic [NPIN-1:0] dis_vec;
  logic [NPIN-1:0] gated_ff;

  assign busy = (state_ff == acr_pkg::ACR_BUSY);

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data are taken separately, the write
  // is applied once both are held and the response is raised with it.
  assign wr_fire = !awready_ff && !wready_ff && !bvalid_ff;
  assign wr_idx = 4'(awaddr_ff[ADDR_W-1:2]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      awaddr_ff <= '0;
    end else if (s_axi_awvalid && awready_ff) begin
      awready_ff <= 1'b0;
      awaddr_ff <= s_axi_awaddr;
    end else if (bvalid_ff && s_axi_bready) begin
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_ff <= 1'b1;
      wdata_ff <= acr_pkg::RST_REG8;
      wstrb0_ff <= 1'b0;
    end else if (s_axi_wvalid && wready_ff) begin
      wready_ff <= 1'b0;
      wdata_ff <= s_axi_wdata[7:0];
      wstrb0_ff <= s_axi_wstrb[0];
    end else if (bvalid_ff && s_axi_bready) begin
      wready_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= acr_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (wr_idx >= acr_pkg::IDX_INPUT_DISABLE_0 &&
                   wr_idx <= acr_pkg::IDX_ALIGN_CTRL) ? acr_pkg::RESP_OKAY
                                                      : acr_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path: data is returned one cycle after the address.
  assign rd_fire = s_axi_arvalid && arready_ff;
  assign rd_idx = 4'(s_axi_araddr[ADDR_W-1:2]);

  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    case (rd_idx)
      acr_pkg::IDX_INPUT_DISABLE_0: rd_byte = dis0_ff;
      acr_pkg::IDX_INPUT_DISABLE_1: rd_byte = dis1_ff & acr_pkg::DIS1_MASK;
      acr_pkg::IDX_CONVERTER_CTRL_B: rd_byte = ctrl_b_ff & acr_pkg::CB_MASK;
      acr_pkg::IDX_RESULT_LOW: begin
        if (left_ff) begin
          rd_byte = {result_ff[1:0], 6'h00};
        end else begin
          rd_byte = result_ff[7:0];
        end
      end
      acr_pkg::IDX_RESULT_HIGH: begin
        if (left_ff) begin
          rd_byte = result_ff[9:2];
        end else begin
          rd_byte = {6'h00, result_ff[9:8]};
        end
      end
      acr_pkg::IDX_CONVERTER_CTRL_A: rd_byte = {en_ff, busy, auto_ff, flag_ff, ie_ff, div_sel_ff};
      acr_pkg::IDX_ALIGN_CTRL: rd_byte = {7'h00, left_ff};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= acr_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h00_0000, rd_byte};
      rresp_ff <= rd_hit ? acr_pkg::RESP_OKAY : acr_pkg::RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Plain control registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dis0_ff <= acr_pkg::RST_REG8;
      dis1_ff <= acr_pkg::RST_REG8;
      ctrl_b_ff <= acr_pkg::RST_REG8;
      left_ff <= 1'b0;
      en_ff <= 1'b0;
      auto_ff <= 1'b0;
      ie_ff <= 1'b0;
      div_sel_ff <= 3'h0;
    end else if (wr_fire && wstrb0_ff) begin
      case (wr_idx)
        acr_pkg::IDX_INPUT_DISABLE_0: dis0_ff <= wdata_ff;
        acr_pkg::IDX_INPUT_DISABLE_1: dis1_ff <= wdata_ff & acr_pkg::DIS1_MASK;
        acr_pkg::IDX_CONVERTER_CTRL_B: ctrl_b_ff <= wdata_ff & acr_pkg::CB_MASK;
        acr_pkg::IDX_ALIGN_CTRL: left_ff <= wdata_ff[acr_pkg::AL_LEFT];
        acr_pkg::IDX_CONVERTER_CTRL_A: begin
          en_ff <= wdata_ff[acr_pkg::CA_ENABLE];
          auto_ff <= wdata_ff[acr_pkg::CA_AUTO];
          ie_ff <= wdata_ff[acr_pkg::CA_IE];
          div_sel_ff <= wdata_ff[acr_pkg::CA_DIV_HI -: 3];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion flag: a finish in the same cycle as a clear keeps it set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_ff <= 1'b0;
    end else if (busy && conv_finished) begin
      flag_ff <= 1'b1;
    end else if (irq_vector_ack) begin
      flag_ff <= 1'b0;
    end else if (wr_fire && wstrb0_ff && wr_idx == acr_pkg::IDX_CONVERTER_CTRL_A &&
                 wdata_ff[acr_pkg::CA_FLAG]) begin
      flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= flag_ff && ie_ff && global_irq_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter clock prescaler; it runs only while the converter is enabled.
  always_comb begin
    if (div_sel_ff <= acr_pkg::DIV_MIN_CODE) begin
      div_limit = 7'h01;
    end else begin
      div_limit = 7'((8'h01 << div_sel_ff) - 8'h01);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !en_ff) begin
      presc_ff <= 7'h00;
      tick_ff <= 1'b0;
    end else if (presc_ff >= div_limit) begin
      presc_ff <= 7'h00;
      tick_ff <= 1'b1;
    end else begin
      presc_ff <= presc_ff + 7'h01;
      tick_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger selection and edge detection. Code zero reads as a low level,
  // so switching to free running never yields an edge.
  always_comb begin
    case (ctrl_b_ff[acr_pkg::CB_TRIG_HI -: 3])
      acr_pkg::TRIG_FREE: trig_level = 1'b0;
      default: trig_level = trigger_flags[ctrl_b_ff[acr_pkg::CB_TRIG_HI -: 3]];
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_prev_ff <= 1'b0;
    end else begin
      trig_prev_ff <= trig_level;
    end
  end

  // The previous level belongs to whichever source was selected, so a change
  // of source from a low flag to a high one looks like a rising edge.
  assign trig_edge = trig_level && !trig_prev_ff;
  assign auto_start = en_ff && auto_ff && trig_edge;
  assign free_start = en_ff && auto_ff && busy && conv_finished &&
                      ctrl_b_ff[acr_pkg::CB_TRIG_HI -: 3] == acr_pkg::TRIG_FREE;
  assign sw_start = wr_fire && wstrb0_ff && wr_idx == acr_pkg::IDX_CONVERTER_CTRL_A &&
                    wdata_ff[acr_pkg::CA_ENABLE] && wdata_ff[acr_pkg::CA_START];
  assign start_req = (sw_start || auto_start) && !busy;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencing.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= acr_pkg::ACR_IDLE;
      start_ff <= 1'b0;
      abort_ff <= 1'b0;
    end else begin
      start_ff <= 1'b0;
      abort_ff <= 1'b0;
      case (state_ff)
        acr_pkg::ACR_IDLE: begin
          if (start_req) begin
            state_ff <= acr_pkg::ACR_BUSY;
            start_ff <= 1'b1;
          end
        end
        acr_pkg::ACR_BUSY: begin
          if (!en_ff) begin
            state_ff <= acr_pkg::ACR_IDLE;
            abort_ff <= 1'b1;
          end else if (conv_finished) begin
            state_ff <= free_start ? acr_pkg::ACR_BUSY : acr_pkg::ACR_IDLE;
            start_ff <= free_start;
          end
        end
        default: state_ff <= acr_pkg::ACR_IDLE;
      endcase
    end
  end

  // Channel msb reaches the mux only between conversions.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ch_msb_eff_ff <= 1'b0;
    end else if (!busy || conv_finished) begin
      ch_msb_eff_ff <= ctrl_b_ff[acr_pkg::CB_CH_MSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result formatting and the read lock.
  always_comb begin
    if (ctrl_b_ff[acr_pkg::CB_BIPOLAR]) begin
      conv_value = conv_raw[10:1];
    end else if (conv_raw[10] || conv_raw == 11'h000) begin
      conv_value = acr_pkg::RESULT_SAT;
    end else begin
      conv_value = conv_raw[9:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_ff <= acr_pkg::RST_RESULT;
    end else if (busy && conv_finished && !lock_ff) begin
      result_ff <= conv_value;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_ff <= 1'b0;
    end else if (rd_fire && rd_idx == acr_pkg::IDX_RESULT_HIGH) begin
      lock_ff <= 1'b0;
    end else if (rd_fire && rd_idx == acr_pkg::IDX_RESULT_LOW) begin
      lock_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Digital input gating per pin: index 0..10 analog pins, 11 reference pin.
  assign dis_vec = {dis0_ff[3], dis1_ff[7:4], dis0_ff[7:4], dis0_ff[2:0]};

  generate
    for (genvar i = 0; i < NPIN; i++) begin : g_pin
      logic sync1_ff, sync2_ff;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sync1_ff <= 1'b0;
          sync2_ff <= 1'b0;
          gated_ff[i] <= 1'b0;
        end else begin
          sync1_ff <= pin_in[i];
          sync2_ff <= sync1_ff;
          gated_ff[i] <= sync2_ff && !dis_vec[i];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign conv_done_irq = irq_ff;
  assign conv_start = start_ff;
  assign conv_abort = abort_ff;
  assign converter_enable = en_ff;
  assign conv_clk_tick = tick_ff;
  assign bipolar_select = ctrl_b_ff[acr_pkg::CB_BIPOLAR];
  assign gain_boost_select = ctrl_b_ff[acr_pkg::CB_GAIN];
  assign reference_select_ext = ctrl_b_ff[acr_pkg::CB_REF_EXT];
  assign channel_select_msb = ch_msb_eff_ff;
  assign pin_in_gated = gated_ff;
  assign pin_buffer_disable = dis_vec;

endmodule // acr_adc_ctrl

// *** acr_adc_ctrl_monitor.sv ***
`timescale 1ns/1ps
module acr_adc_ctrl_monitor #(
  parameter int NPIN = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic global_irq_enable,
  input wire logic irq_vector_ack,
  input wire logic conv_done_irq,
  input wire logic conv_finished,
  input wire logic conv_start,
  input wire logic conv_abort,
  input wire logic converter_enable,
  input wire logic conv_clk_tick,
  input wire logic [NPIN-1:0] pin_in,
  input wire logic [NPIN-1:0] pin_in_gated,
  input wire logic [NPIN-1:0] pin_buffer_disable
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////
  property p_irq_gie;
    conv_done_irq |-> $past(global_irq_enable);
  endproperty
  a_irq_gie: assert property (p_irq_gie) else $error("irq without global enable");
  property p_ack_clr;
    irq_vector_ack && !conv_finished |-> ##2 !conv_done_irq;
  endproperty
  a_ack_clr: assert property (p_ack_clr) else $error("irq stays after vector ack");
  property p_tick_gap;
    conv_clk_tick |=> !conv_clk_tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick period below two");
  property p_tick_en;
    conv_clk_tick |-> $past(converter_enable);
  endproperty
  a_tick_en: assert property (p_tick_en) else $error("tick while disabled");
  property p_start_one;
    conv_start |=> !conv_start;
  endproperty
  a_start_one: assert property (p_start_one) else $error("start pulse too long");
  property p_start_en;
    conv_start |-> converter_enable;
  endproperty
  a_start_en: assert property (p_start_en) else $error("start while disabled");
  property p_abort;
    $rose(conv_abort) |-> !converter_enable && !$past(converter_enable) &&
      $past(converter_enable, 2);
  endproperty
  a_abort: assert property (p_abort) else $error("abort without enable clear");
  property p_pin_gate;
    $past(aresetn, 3) && $past(aresetn, 2) && $past(aresetn) |->
      pin_in_gated == ($past(pin_in, 3) & ~$past(pin_buffer_disable));
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("pin gating wrong");
endmodule // acr_adc_ctrl_monitor

bind acr_adc_ctrl acr_adc_ctrl_monitor #(.NPIN(NPIN)) u_mon (.aclk(aclk), .aresetn(aresetn),
  .global_irq_enable(global_irq_enable), .irq_vector_ack(irq_vector_ack),
  .conv_done_irq(conv_done_irq), .conv_finished(conv_finished), .conv_start(conv_start),
  .conv_abort(conv_abort), .converter_enable(converter_enable), .conv_clk_tick(conv_clk_tick),
  .pin_in(pin_in), .pin_in_gated(pin_in_gated), .pin_buffer_disable(pin_buffer_disable));

// *** acr_tb.sv ***
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [10:0] r;
    logic b;
    logic l;
    logic [7:0] lo;
    logic [7:0] hi;
  } acr_row_s;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, gie, ack, fin;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic [10:0] raw;
  logic [7:1] tflags;
  logic [11:0] pins;
  logic awready, wready, bvalid, arready, rvalid, irq, cstart, cabort, cen, tick;
  logic bip, gain, refx, chm;
  logic [1:0] bresp, rresp, rd_r;
  logic [31:0] rdata;
  logic [11:0] gated, pdis;
  logic [7:0] rd_d;
  int mismatches, n_tests, n_start, n_abort, i, s, p;
  acr_row_s rows [8] = '{'{11'h155, 1'b0, 1'b0, 8'h55, 8'h01}, '{11'h2c6, 1'b0, 1'b1, 8'h80, 8'hb1},
    '{11'h7f0, 1'b0, 1'b0, 8'hff, 8'h03}, '{11'h000, 1'b0, 1'b1, 8'hc0, 8'hff},
    '{11'h7f0, 1'b1, 1'b0, 8'hf8, 8'h03}, '{11'h2ab, 1'b1, 1'b1, 8'h40, 8'h55},
    '{11'h002, 1'b1, 1'b0, 8'h01, 8'h00}, '{11'h200, 1'b0, 1'b1, 8'h00, 8'h80}};

  acr_adc_ctrl #(.ADDR_W(6), .NPIN(12)) DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .global_irq_enable(gie),
    .irq_vector_ack(ack), .conv_done_irq(irq), .trigger_flags(tflags), .conv_finished(fin),
    .conv_raw(raw), .conv_start(cstart), .conv_abort(cabort), .converter_enable(cen),
    .conv_clk_tick(tick), .bipolar_select(bip), .gain_boost_select(gain),
    .reference_select_ext(refx), .channel_select_msb(chm), .pin_in(pins), .pin_in_gated(gated),
    .pin_buffer_disable(pdis));

  ////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (cstart === 1'b1) n_start++;
    if (cabort === 1'b1) n_abort++;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= {a, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rd_r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    araddr <= {a, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd_d = rdata[7:0];
    rd_r = rresp;
    rready <= 1'b0;
  endtask
  task automatic conv(input logic [10:0] r);
    @(posedge aclk);
    fin <= 1'b1;
    raw <= r;
    @(posedge aclk);
    fin <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic print_verdict;
    if (mismatches == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge aclk);
    mismatches++;
    print_verdict;
  end

  ////////////////////////////////////////////////////////////
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, gie, ack, fin} = '0;
    {awaddr, araddr, wdata, raw, tflags, pins} = '0;
    wstrb = 4'h1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 1; i < 8; i++) begin
      rd(i[3:0]);
      chk(rd_d, 8'h00);
    end
    rd(4'h0);
    chk({rd_r, rd_d}, {acr_pkg::RESP_SLVERR, 8'h00});
    wr(4'h8, 8'hff);
    chk(rd_r, acr_pkg::RESP_SLVERR);
    for (i = 0; i < 8; i++) begin
      wr(4'h3, {rows[i].b, 7'h0});
      wr(4'h7, {7'h0, rows[i].l});
      wr(4'h6, 8'hc0 | i[7:0]);
      conv(rows[i].r);
      rd(4'h6);
      chk(rd_d, 8'h90 | i[7:0]);
      rd(4'h4);
      chk(rd_d, rows[i].lo);
      rd(4'h5);
      chk(rd_d, rows[i].hi);
      for (int n = 0; n < 300; n++) begin
        @(posedge aclk);
        if (tick === 1'b1) break;
      end
      for (p = 1; p < 300; p++) begin
        @(posedge aclk);
        if (tick === 1'b1) break;
      end
      chk(p, (i < 2) ? 2 : (1 << i));
      wr(4'h6, 8'h90 | i[7:0]);
    end
    // Result lock: a low read freezes both bytes until the high read.
    wr(4'h3, 8'h00);
    wr(4'h7, 8'h00);
    wr(4'h6, 8'hc0);
    conv(11'h123);
    rd(4'h4);
    chk(rd_d, 8'h23);
    wr(4'h6, 8'hd0);
    conv(11'h0ab);
    rd(4'h6);
    chk(rd_d, 8'h90);
    rd(4'h5);
    chk(rd_d, 8'h01);
    wr(4'h6, 8'hd0);
    conv(11'h0ab);
    rd(4'h4);
    chk(rd_d, 8'hab);
    rd(4'h5);
    chk(rd_d, 8'h00);
    // Interrupt request, vector clear and write-one-to-clear.
    wr(4'h6, 8'hd8);
    conv(11'h001);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0);
    gie <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(irq, 1'b1);
    wr(4'h6, 8'h88);
    rd(4'h6);
    chk({irq, rd_d}, {1'b1, 8'h98});
    ack <= 1'b1;
    @(posedge aclk);
    ack <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0);
    wr(4'h6, 8'hc8);
    conv(11'h001);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b1);
    wr(4'h6, 8'h98);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0);
    gie <= 1'b0;
    // Abort, then a late finish must not set the flag.
    s = n_abort;
    wr(4'h6, 8'hc0);
    wr(4'h6, 8'h00);
    conv(11'h003);
    chk(n_abort - s, 1);
    rd(4'h6);
    chk({cen, rd_d}, 9'h000);
    // Auto trigger for every selectable source.
    wr(4'h6, 8'ha0);
    for (i = 1; i < 8; i++) begin
      wr(4'h3, i[7:0]);
      s = n_start;
      tflags <= 7'(1 << (i - 1));
      repeat (3) @(posedge aclk);
      chk(n_start - s, 1);
      conv(11'h001);
      tflags <= 7'h00;
    end
    tflags <= 7'h02;
    wr(4'h3, 8'h01);
    s = n_start;
    wr(4'h3, 8'h02);
    repeat (2) @(posedge aclk);
    chk(n_start - s, 1);
    conv(11'h001);
    tflags <= 7'h00;
    s = n_start;
    wr(4'h3, 8'h00);
    repeat (3) @(posedge aclk);
    chk(n_start, s);
    wr(4'h6, 8'he0);
    conv(11'h001);
    repeat (2) @(posedge aclk);
    chk(n_start - s, 2);
    wr(4'h6, 8'h80);
    conv(11'h001);
    s = n_start;
    wr(4'h6, 8'h90);
    wr(4'h3, 8'h01);
    tflags <= 7'h01;
    repeat (3) @(posedge aclk);
    chk(n_start, s);
    tflags <= 7'h00;
    // Control B fields, reserved bit and deferred channel bit.
    wr(4'h6, 8'h00);
    wr(4'h3, 8'hff);
    chk(rd_r, acr_pkg::RESP_OKAY);
    rd(4'h3);
    chk({rd_r, rd_d}, {acr_pkg::RESP_OKAY, 8'hdf});
    chk({bip, gain, refx, chm}, 4'hf);
    wr(4'h3, 8'h00);
    wr(4'h6, 8'hc0);
    wr(4'h3, 8'h08);
    @(posedge aclk);
    chk(chm, 1'b0);
    conv(11'h001);
    chk(chm, 1'b1);
    // Digital input disables; a write without the low lane is dropped.
    pins <= 12'hfff;
    wstrb <= 4'he;
    wr(4'h1, 8'hff);
    wstrb <= 4'h1;
    rd(4'h1);
    chk(rd_d, 8'h00);
    wr(4'h1, 8'hff);
    wr(4'h2, 8'hff);
    rd(4'h2);
    chk(rd_d, 8'hf0);
    repeat (4) @(posedge aclk);
    chk({pdis, gated}, {12'hfff, 12'h000});
    wr(4'h1, 8'h08);
    wr(4'h2, 8'h00);
    repeat (4) @(posedge aclk);
    chk({pdis, gated}, {12'h800, 12'h7ff});
    wr(4'h1, 8'ha5);
    wr(4'h2, 8'h90);
    repeat (4) @(posedge aclk);
    chk({pdis, gated}, {12'h4d5, 12'hb2a});
    print_verdict;
  end
endmodule // testbench
